// *** core/i2cfl_pkg.sv ***
package i2cfl_pkg;
    // -------------------------------------------------------------------
    // register indices
    // -------------------------------------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_MASK   = 4'h2;
    localparam logic [3:0] REG_ADDR   = 4'h3;
    localparam logic [3:0] REG_DATA   = 4'h4;
    localparam logic [3:0] REG_CMD    = 4'h5;
    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int CTRL_EN        = 0;
    localparam int CTRL_TO_EN     = 1;
    localparam int ST_DATA_FLAG   = 0;
    localparam int ST_ADDR_FLAG   = 1;
    localparam int ST_COLL        = 2;
    localparam int ST_TOUT        = 3;
    localparam int ST_HOLD        = 4;
    localparam int ST_DIR         = 5;
    localparam int ST_BUS_LO      = 6;
    localparam int NUM_IRQ        = 4;
    // -------------------------------------------------------------------
    // encodings and reset values
    // -------------------------------------------------------------------
    localparam logic [1:0] BUS_UNKNOWN  = 2'h0;
    localparam logic [1:0] BUS_IDLE     = 2'h1;
    localparam logic [1:0] BUS_BUSY     = 2'h3;
    localparam logic [1:0] CMD_RESPOND  = 2'h2;
    localparam logic [1:0] CMD_COMPLETE = 2'h3;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [6:0] ADDR_RESET   = 7'h00;
    localparam logic [3:0] MASK_RESET   = 4'h0;
    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 8;
    localparam int TIMEOUT_US     = 100;
    localparam int TIMEOUT_CYCLES = TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int BIT_COUNT      = 8;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDRESS, ST_ACK, ST_RX, ST_TX, ST_MACK, ST_WAIT
    } i2cfl_state_t;
endpackage : i2cfl_pkg

// *** core/i2cfl_slave.sv ***
`timescale 1ns/1ps
module i2cfl_slave
    import i2cfl_pkg::*;
#(
    parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    output logic            irq
);
    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    function automatic logic flag_next(input logic cur, input logic set, input logic clr);
        flag_next = set | (cur & ~clr);
    endfunction : flag_next

    // -------------------------------------------------------------------
    // pin synchronisers and edge detect
    // -------------------------------------------------------------------
    logic       scl_meta, scl_sync, scl_prev;
    logic       sda_meta, sda_sync, sda_prev;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {scl_meta, scl_sync, scl_prev} <= 3'h7;
            {sda_meta, sda_sync, sda_prev} <= 3'h7;
        end else begin
            {scl_meta, scl_sync, scl_prev} <= {scl_i, scl_meta, scl_sync};
            {sda_meta, sda_sync, sda_prev} <= {sda_i, sda_meta, sda_sync};
        end
    end
    wire scl_rise  = scl_sync & ~scl_prev;
    wire scl_fall  = ~scl_sync & scl_prev;
    wire start_det = scl_sync & scl_prev & sda_prev & ~sda_sync;
    wire stop_det  = scl_sync & scl_prev & ~sda_prev & sda_sync;

    // -------------------------------------------------------------------
    // registers and state
    // -------------------------------------------------------------------
    i2cfl_state_t state, next_state;
    logic [7:0]   ctrl;
    logic [6:0]   own_addr;
    logic [3:0]   mask;
    logic [7:0]   data;
    logic [7:0]   shift;
    logic [3:0]   bit_cnt;
    logic         data_irq_flag, address_stop_irq_flag, coll, tout, hold, dir, addressed;
    logic         data_clr_pend;
    logic [1:0]   bus_state;
    logic [31:0]  to_cnt;

    wire enabled    = ctrl[CTRL_EN];
    wire wr_status  = reg_wr & (reg_addr == REG_STATUS);
    wire wr_cmd     = reg_wr & (reg_addr == REG_CMD);
    wire cmd_resp   = wr_cmd & (reg_wdata[1:0] == CMD_RESPOND);
    wire cmd_done   = wr_cmd & (reg_wdata[1:0] == CMD_COMPLETE);
    wire byte_done  = scl_fall & (bit_cnt == 4'(BIT_COUNT));
    wire tx_bit     = data[3'(BIT_COUNT - 1) - bit_cnt[2:0]];
    wire timeout    = ctrl[CTRL_TO_EN] & (bus_state == BUS_BUSY) &
                      (to_cnt >= 32'(TIMEOUT_LIMIT));
    wire drop_start = start_det & timeout;
    wire addr_match = (state == ST_ADDRESS) & byte_done &
                      (shift[7:1] == own_addr);
    wire set_addr_flag = addr_match | (stop_det & addressed);
    wire set_data_flag = ((state == ST_RX) & byte_done) |
                         ((state == ST_MACK) & scl_fall & ~shift[0]);
    wire set_coll      = (state == ST_TX) & scl_rise & tx_bit & ~sda_sync;
    wire clr_coll      = (start_det & (bus_state != BUS_BUSY)) |
                         (wr_status & reg_wdata[ST_COLL]);
    wire clr_tout      = wr_status & reg_wdata[ST_TOUT];
    wire clr_addr_flag = wr_status & reg_wdata[ST_ADDR_FLAG];
    wire clr_data_flag = (wr_status & reg_wdata[ST_DATA_FLAG]) | cmd_resp |
                         data_clr_pend;
    wire set_hold      = addr_match | set_data_flag;
    // a clear racing a set is swallowed, hold stays asserted
    wire rel_hold      = (clr_addr_flag & ~set_addr_flag) |
                         (clr_data_flag & ~set_data_flag) | cmd_done;
    wire [7:0] status_word = {bus_state, dir, hold, tout, coll,
                              address_stop_irq_flag, data_irq_flag};

    // -------------------------------------------------------------------
    // next flag values, set wins over clear
    // -------------------------------------------------------------------
    wire next_data_irq_flag = flag_next(data_irq_flag, set_data_flag, clr_data_flag);
    wire next_address_stop_irq_flag = flag_next(address_stop_irq_flag, set_addr_flag,
                                                clr_addr_flag);
    wire next_coll = flag_next(coll, set_coll, clr_coll);
    wire next_tout = flag_next(tout, timeout, clr_tout);
    wire next_hold = flag_next(hold, set_hold, rel_hold) & enabled;

    // -------------------------------------------------------------------
    // protocol state machine
    // -------------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:    next_state = ST_IDLE;
            ST_ADDRESS: if (byte_done) next_state = addr_match ? ST_ACK : ST_WAIT;
            ST_ACK:     if (scl_fall) next_state = dir ? ST_TX : ST_RX;
            ST_RX:      if (byte_done) next_state = ST_ACK;
            ST_TX:      if (byte_done) next_state = ST_MACK;
            ST_MACK:    if (scl_fall) next_state = shift[0] ? ST_WAIT : ST_TX;
            ST_WAIT:    next_state = ST_WAIT;
        endcase
        if (cmd_done) next_state = ST_WAIT;
        if (start_det) next_state = ST_ADDRESS;
        if (stop_det | timeout | ~enabled | drop_start) next_state = ST_IDLE;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state   <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
        end else begin
            state <= next_state;
            if (next_state != state || start_det) begin
                bit_cnt <= 4'h0;
            end else if (scl_rise) begin
                bit_cnt <= bit_cnt + 4'h1;
                shift   <= {shift[6:0], sda_sync};
            end
        end
    end

    // -------------------------------------------------------------------
    // flags, hold and bus monitor
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {data_irq_flag, address_stop_irq_flag, coll, tout, hold, dir} <= 6'h00;
            addressed    <= 1'b0;
            data_clr_pend <= 1'b0;
            bus_state    <= BUS_UNKNOWN;
            to_cnt       <= 32'h0000_0000;
        end else begin
            data_irq_flag         <= next_data_irq_flag;
            address_stop_irq_flag <= next_address_stop_irq_flag;
            coll                  <= next_coll;
            tout                  <= next_tout;
            hold                  <= next_hold;
            data_clr_pend         <= cmd_done;
            if (addr_match) dir <= shift[0];
            if (addr_match) addressed <= 1'b1;
            else if (stop_det | timeout) addressed <= 1'b0;
            if (~enabled) begin
                bus_state <= BUS_UNKNOWN;
            end else if (drop_start | stop_det | timeout) begin
                bus_state <= BUS_IDLE;
            end else if (start_det) begin
                bus_state <= BUS_BUSY;
            end else if (bus_state == BUS_UNKNOWN) begin
                bus_state <= BUS_IDLE;
            end
            if (scl_rise | scl_fall | (bus_state != BUS_BUSY) | timeout)
                to_cnt <= 32'h0000_0000;
            else
                to_cnt <= to_cnt + 32'h0000_0001;
        end
    end

    // -------------------------------------------------------------------
    // register port
    // -------------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            REG_CTRL:   rd_mux = ctrl;
            REG_STATUS: rd_mux = status_word;
            REG_MASK:   rd_mux = {4'h0, mask};
            REG_ADDR:   rd_mux = {own_addr, 1'b0};
            REG_DATA:   rd_mux = data;
            default:    rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl      <= CTRL_RESET;
            own_addr  <= ADDR_RESET;
            mask      <= MASK_RESET;
            data      <= 8'h00;
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            if (reg_wr && reg_addr == REG_CTRL) ctrl <= reg_wdata;
            if (reg_wr && reg_addr == REG_MASK) mask <= reg_wdata[NUM_IRQ-1:0];
            if (reg_wr && reg_addr == REG_ADDR) own_addr <= reg_wdata[7:1];
            if (state == ST_RX && byte_done) data <= shift;
            else if (reg_wr && reg_addr == REG_DATA) data <= reg_wdata;
        end
    end

    // -------------------------------------------------------------------
    // pins and interrupt
    // -------------------------------------------------------------------
    assign scl_o  = 1'b0;
    assign scl_oe = hold;
    assign sda_o  = 1'b0;
    assign sda_oe = (state == ST_ACK) | ((state == ST_TX) & ~tx_bit &
                    (bit_cnt < 4'(BIT_COUNT)));
    assign irq    = |(status_word[NUM_IRQ-1:0] & mask);
endmodule : i2cfl_slave

// *** testbench/i2cfl_monitor.sv ***
`timescale 1ns/1ps
module i2cfl_monitor
    import i2cfl_pkg::*;
(
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       scl_i,
    input wire logic       scl_oe
);
    // ----
    // port checks
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence rd_st;
        reg_rd && reg_addr == REG_STATUS;
    endsequence
    sequence wr_st(v);
        reg_wr && reg_addr == REG_STATUS && reg_wdata == v;
    endsequence
    sequence cmd_done;
        reg_wr && reg_addr == REG_CMD && reg_wdata[1:0] == CMD_COMPLETE;
    endsequence
    data_stale_a: assert property (
        rd_st ##1 reg_rdata[ST_DATA_FLAG] ##1 cmd_done ##1 rd_st
        |=> reg_rdata[ST_DATA_FLAG])
        else $error("data flag gone early");
    rdata_quiet_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
    zero_keep_a: assert property (
        rd_st ##2 wr_st(8'h00) ##1 rd_st
        |=> (reg_rdata & $past(reg_rdata, 3) & 8'h0F) == ($past(reg_rdata, 3) & 8'h0F))
        else $error("zero write cleared a flag");
    one_clear_a: assert property (
        rd_st ##1 reg_rdata[ST_ADDR_FLAG] ##1 wr_st(8'h02) ##1 (rd_st ##0 !scl_oe)
        |=> !reg_rdata[ST_ADDR_FLAG]) else $error("flag not cleared");
    hold_keep_a: assert property (
        scl_oe && !reg_wr && !$past(reg_wr) |=> scl_oe) else $error("hold dropped");
    hold_low_a: assert property (
        $rose(scl_oe) |-> !$past(scl_i)) else $error("hold with scl high");
endmodule : i2cfl_monitor
bind i2cfl_slave i2cfl_monitor i2cfl_monitor_inst (
    .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scl_i, .scl_oe
);

// *** testbench/i2cfl_master_model.sv ***
`timescale 1ns/1ps
module i2cfl_master_model (
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_m = 1'b1,
    output logic      sda_m = 1'b1
);
    // ----
    // bus master, 125 ns bit
    // ----
    logic ack = 1'b1;
    task automatic pulse();
        #31.25;
        scl_m = 1'b1;
        wait (scl_line === 1'b1);
        #62.5;
        ack = sda_line;
        scl_m = 1'b0;
        #31.25;
    endtask : pulse
    task automatic start();
        sda_m = 1'b1;
        #31.25;
        scl_m = 1'b1;
        #62.5;
        sda_m = 1'b0;
        #62.5;
        scl_m = 1'b0;
        #31.25;
    endtask : start
    task automatic stop();
        sda_m = 1'b0;
        #31.25;
        scl_m = 1'b1;
        #62.5;
        sda_m = 1'b1;
        #62.5;
    endtask : stop
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda_m = b[i];
            pulse();
        end
        sda_m = 1'b1;
        pulse();
    endtask : send
endmodule : i2cfl_master_model

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import i2cfl_pkg::*;
;
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata, v;
    logic       scl_o, scl_oe, sda_o, sda_oe, irq, scl_m, sda_m;
    wire        scl_w = scl_m & (~scl_oe | scl_o);
    wire        sda_w = sda_m & (~sda_oe | sda_o);
    int         errors = 0;
    int         total_checks = 0;
    int         cycles = 0;
    always #4 clk = ~clk;
    i2cfl_slave #(.TIMEOUT_LIMIT(50)) i2cfl_slave_inst (
        .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .scl_i(scl_w), .scl_o, .scl_oe, .sda_i(sda_w), .sda_o, .sda_oe, .irq
    );
    i2cfl_master_model m (.scl_line(scl_w), .sda_line(sda_w), .scl_m, .sda_m);
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk) v = reg_rdata;
        @(posedge clk);
    endtask : rd
    task automatic wait_irq();
        repeat (3) @(posedge clk);
        repeat (4000) if (irq !== 1'b1) @(posedge clk);
        check({7'h0, irq}, 8'h01);
    endtask : wait_irq
    task automatic test_miss();
        m.start();
        m.send(8'h20);
        check({7'h0, m.ack}, 8'h01);
        m.stop();
        @(posedge clk);
        check({7'h0, irq}, 8'h00);
        $display("test miss done");
    endtask : test_miss
    task automatic test_rx();
        fork
            begin
                m.start();
                m.send(8'h54);
                m.send(8'hA5);
                check({7'h0, m.ack}, 8'h01);
                m.stop();
            end
            begin
                wait_irq();
                rd(REG_STATUS);
                check(v, 8'hD2);
                check({7'h0, scl_w}, 8'h00);
                wr(REG_STATUS, 8'h06);
                wait_irq();
                rd(REG_DATA);
                check(v, 8'hA5);
                rd(REG_STATUS);
                wr(REG_STATUS, 8'h00);
                rd(REG_STATUS);
                check(v, 8'hD1);
                wr(REG_CMD, {6'h00, CMD_COMPLETE});
                rd(REG_STATUS);
                check({7'h0, v[ST_DATA_FLAG]}, 8'h01);
                @(posedge clk);
                rd(REG_STATUS);
                check({7'h0, v[ST_DATA_FLAG]}, 8'h00);
            end
        join
        $display("test rx done");
    endtask : test_rx
    task automatic test_stop();
        wait_irq();
        rd(REG_STATUS);
        check(v, 8'h42);
        wr(REG_MASK, 8'h00);
        @(posedge clk);
        check({7'h0, irq}, 8'h00);
        wr(REG_MASK, 8'h0F);
        rd(REG_STATUS);
        wr(REG_STATUS, 8'h02);
        rd(REG_STATUS);
        check(v, 8'h40);
        $display("test stop done");
    endtask : test_stop
    task automatic test_coll();
        wr(REG_DATA, 8'hFF);
        fork
            begin
                m.start();
                m.send(8'h55);
                check({7'h0, m.ack}, 8'h00);
            end
            begin
                wait_irq();
                rd(REG_STATUS);
                check(v, 8'hF2);
                wr(REG_STATUS, 8'h02);
            end
        join
        m.send(8'h00);
        m.stop();
        @(posedge clk);
        rd(REG_STATUS);
        check(v, 8'h66);
        wr(REG_STATUS, 8'h02);
        m.start();
        m.send(8'h20);
        m.stop();
        @(posedge clk);
        rd(REG_STATUS);
        check(v, 8'h60);
        $display("test coll done");
    endtask : test_coll
    task automatic test_timeout();
        wr(REG_CTRL, 8'h03);
        m.start();
        repeat (80) @(posedge clk);
        check({7'h0, irq}, 8'h01);
        rd(REG_STATUS);
        check(v, 8'h68);
        wr(REG_STATUS, 8'h08);
        m.stop();
        @(posedge clk);
        wr(REG_CTRL, 8'h01);
        check({7'h0, irq}, 8'h00);
        $display("test timeout done");
    endtask : test_timeout
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        wr(REG_CTRL, 8'h01);
        @(posedge clk);
        wr(REG_ADDR, 8'h54);
        @(posedge clk);
        wr(REG_MASK, 8'h0F);
        test_miss();
        test_rx();
        test_stop();
        test_coll();
        test_timeout();
        summarize();
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end
endmodule : tb_top
